// ### mip_host_model.sv
// Purpose: Host controller driving the serial link of the flash.
// Assumes: Link clock of 15 ns, moving only inside frames.
// Notes: Released lines show the inverse of their last value.
module mip_host_model import mip_pkg::*; (
    // Link
    output logic spiClk,
    output logic csN,
    output logic siH,
    output logic soH,
    output logic wpH,
    output logic holdH,
    // Resolved output line
    input wire logic soLine
);
    timeunit 1ns;
    timeprecision 100ps;
    logic lastSo;
    initial begin
        {spiClk, csN, siH, soH, wpH, holdH} = 6'h1F;
        lastSo = 1'b0;
    end
    // ****
    // Link primitives
    // ****
    function automatic logic [7:0] dat(input logic [7:0] seed, input int k);
        return seed ^ k[7:0] ^ (k[8] ? 8'h55 : 8'h00);
    endfunction
    // Lines change while the clock is low
    task automatic tick(input logic [3:0] v);
        {holdH, wpH, soH, siH} = v;
        #7.5;
        lastSo = soLine;
        spiClk = 1'b1;
        #7.5;
        spiClk = 1'b0;
    endtask
    task automatic start(input logic [7:0] op, input logic [23:0] addr, input int hdr);
        logic [31:0] h;
        h = {op, addr};
        csN = 1'b0;
        #4;
        for (int i = 0; i < hdr; i++) tick({2'h3, ~h[31-i], h[31-i]});
    endtask
    task automatic stop();
        #4;
        csN = 1'b1;
        {holdH, wpH, soH, siH} = ~{holdH, wpH, soH, siH};
        #40;
    endtask
    // ****
    // Frames
    // ****
    task automatic send(input logic [7:0] op, input logic [23:0] addr, input int hdr, input int n, input int extra);
        logic [7:0] b;
        start(op, addr, hdr);
        for (int k = 0; k < n; k++) begin
            b = dat(op ^ addr[15:8], k);
            if (op == OPC_QUAD_PROGRAM) begin
                tick(b[7:4]);
                tick(b[3:0]);
            end else begin
                for (int j = 3; j >= 0; j--) tick({2'h3, b[2*j+1], b[2*j]});
            end
        end
        for (int e = 0; e < extra; e++) tick(4'hA);
        stop();
    endtask
    // Polling the driven flag instead of waiting out the program time
    task automatic status(input int maxClk, output logic sawHigh, output logic sawFall);
        sawHigh = 1'b0;
        sawFall = 1'b0;
        start(OPC_ACTIVE_STATUS, 24'h0, 8);
        for (int i = 0; i < maxClk && !sawFall; i++) begin
            tick(4'hF);
            if (i > 2 && lastSo) sawHigh = 1'b1;
            else if (sawHigh && !lastSo) sawFall = 1'b1;
        end
        stop();
    endtask
endmodule

// ### mip_multi_io_page_program.sv
// Purpose: Dual and quad input page program path, link capture to array write.
// Assumes: Link clock runs only while chip select is low; frame state is static after it rises.
// Notes: Core samples link registers only after a synchronised chip-select rise.

module mip_multi_io_page_program
    import mip_pkg::*;
#(
    parameter int PAGE_PROGRAM_TIME_NS = 1000000,
    parameter int BYTE_PROGRAM_TIME_NS = 10000,
    parameter int NUM_BLOCKS = 64,
    parameter int BLOCK_ADDR_LSB = 16
) (
    // Core clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Serial link
    input wire logic spiClk,
    input wire logic csN,
    input wire logic siIn,
    input wire logic soIn,
    output logic soOut,
    output logic soOeN,
    input wire logic wpIn,
    input wire logic holdIn,
    // Configuration and status
    input wire logic writeEnableSet,
    input wire logic writeEnableClear,
    input wire logic quadLaneEnableBit,
    input wire logic [NUM_BLOCKS-1:0] blockLockMap,
    output logic writeEnableLatch,
    output logic readyBusyFlag,
    output logic programAborted,
    // Array write port
    output mip_array_wr_s arrayWrite
);

    // ****************************************
    // Constants
    // ****************************************
    localparam int BLK_BITS = $clog2(NUM_BLOCKS);
    localparam logic [23:0] PP_CYCLES = nsToCycles(PAGE_PROGRAM_TIME_NS);
    localparam logic [23:0] BP_CYCLES = nsToCycles(BYTE_PROGRAM_TIME_NS);

    // ****************************************
    // Link domain declarations
    // ****************************************
    logic inFrame;
    mip_lane_e laneMode;
    logic [5:0] hdrCnt;
    logic [31:0] hdrShift;
    logic [7:0] opcode;
    logic [23:0] startAddr;
    logic [7:0] wrPtr;
    logic [8:0] byteCount;
    logic [7:0] dataShift;
    logic [1:0] dataPhase;
    logic busyLink;
    logic [5:0] effCnt;
    logic [31:0] effShift;
    logic [31:0] next_shift;
    logic [7:0] next_data;
    logic [1:0] lastPhase;
    logic inData;
    logic byteDone;
    logic bufWrEn;
    logic bufClear;
    mip_frame_s linkFrame;

    // ****************************************
    // Core domain declarations
    // ****************************************
    mip_core_e state;
    mip_frame_s captured;
    logic csSync;
    logic csPrev;
    logic frameEnd;
    logic [7:0] copyIdx;
    logic [23:0] timer;
    logic [7:0] rdData;
    logic rdValid;
    logic isQuadCap;
    logic malformed;
    logic locked;
    logic refuse;
    logic checkOk;
    logic checkAbort;
    logic checkClearWel;
    logic programDone;
    logic internalClear;

    // ****************************************
    // Crossings
    // ****************************************
    mip_sync #(.INIT(1'b1)) u_cs_sync (
        .clk(clock),
        .rstN(rst_n),
        .d(csN),
        .q(csSync)
    );

    // Link side has no reset of its own; it settles within two link clocks
    mip_sync #(.INIT(1'b0)) u_busy_sync (
        .clk(spiClk),
        .rstN(1'b1),
        .d(readyBusyFlag),
        .q(busyLink)
    );

    // ****************************************
    // Link decode
    // ****************************************
    always_comb begin
        // First edge of a frame starts from an empty header
        effCnt = inFrame ? hdrCnt : '0;
        effShift = inFrame ? hdrShift : '0;
        next_shift = {effShift[30:0], siIn};
        if (laneMode == LANE_QUAD) begin
            next_data = {dataShift[3:0], holdIn, wpIn, soIn, siIn};
            lastPhase = QUAD_LAST_PHASE;
        end else begin
            next_data = {dataShift[5:0], soIn, siIn};
            lastPhase = DUAL_LAST_PHASE;
        end
        inData = (laneMode != LANE_SINGLE);
        byteDone = inData && (dataPhase == lastPhase);
        // Busy device must not disturb the buffer being copied
        bufWrEn = byteDone && !busyLink;
        bufClear = (effCnt == ADDR_LAST_BIT) && isProgram(opcode) && !busyLink;
        linkFrame.opcode = opcode;
        linkFrame.startAddr = startAddr;
        linkFrame.byteCount = byteCount;
        linkFrame.headerDone = (hdrCnt == HDR_BITS);
        linkFrame.partialByte = (dataPhase != 2'h0);
    end

    // ****************************************
    // Link lane roles and output line
    // ****************************************
    always_ff @(posedge spiClk or posedge csN) begin
        if (csN) begin
            // Chip select high hands every line back to single-lane idle
            inFrame <= 1'b0;
            laneMode <= LANE_SINGLE;
            soOeN <= 1'b1;
            soOut <= 1'b0;
        end else begin
            inFrame <= 1'b1;
            if (effCnt == ADDR_LAST_BIT) begin
                // Output line stays undriven so it serves as a data input
                if (opcode == OPC_DUAL_PROGRAM) begin
                    laneMode <= LANE_DUAL;
                end else if (opcode == OPC_QUAD_PROGRAM) begin
                    laneMode <= LANE_QUAD;
                end
            end
            if ((effCnt == OPC_LAST_BIT) && (next_shift[7:0] == OPC_ACTIVE_STATUS)) begin
                soOeN <= 1'b0;
            end
            soOut <= busyLink;
        end
    end

    // ****************************************
    // Link header capture
    // ****************************************
    always_ff @(posedge spiClk) begin
        if (effCnt < HDR_BITS) begin
            hdrShift <= next_shift;
            hdrCnt <= 6'(effCnt + 6'h01);
        end
        if (effCnt == OPC_LAST_BIT) begin
            opcode <= next_shift[7:0];
        end else if (!inFrame) begin
            opcode <= '0;
        end
        if (effCnt == ADDR_LAST_BIT) begin
            startAddr <= next_shift[23:0];
        end
    end

    // ****************************************
    // Link data assembly
    // ****************************************
    always_ff @(posedge spiClk) begin
        if (!inFrame || (effCnt == ADDR_LAST_BIT)) begin
            dataPhase <= '0;
            dataShift <= '0;
        end else if (inData) begin
            dataShift <= next_data;
            dataPhase <= byteDone ? 2'h0 : 2'(dataPhase + 2'h1);
        end
    end

    always_ff @(posedge spiClk) begin
        if (!inFrame) begin
            byteCount <= '0;
        end else if (byteDone && (byteCount != PAGE_BYTES)) begin
            byteCount <= 9'(byteCount + 9'h001);
        end
    end

    // Eight-bit pointer wraps inside the page
    always_ff @(posedge spiClk) begin
        if (effCnt == ADDR_LAST_BIT) begin
            wrPtr <= next_shift[7:0];
        end else if (bufWrEn) begin
            wrPtr <= 8'(wrPtr + 8'h01);
        end
    end

    mip_page_buf u_page_buf (
        .wrClk(spiClk),
        .clearMask(bufClear),
        .wrEn(bufWrEn),
        .wrIdx(wrPtr),
        .wrData(next_data),
        .rdIdx(copyIdx),
        .rdData(rdData),
        .rdValid(rdValid)
    );

    // ****************************************
    // Core frame end detection
    // ****************************************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            csPrev <= 1'b1;
        end else begin
            csPrev <= csSync;
        end
    end

    assign frameEnd = csSync && !csPrev;

    // ****************************************
    // Core acceptance checks
    // ****************************************
    always_comb begin
        isQuadCap = (captured.opcode == OPC_QUAD_PROGRAM);
        malformed = !captured.headerDone || (captured.byteCount == 9'h000) || captured.partialByte;
        locked = blockLockMap[captured.startAddr[BLOCK_ADDR_LSB +: BLK_BITS]];
        refuse = !writeEnableLatch || (isQuadCap && !quadLaneEnableBit);
        checkOk = !refuse && !malformed && !locked;
        checkAbort = !refuse && (malformed || locked);
        // Dual malformed frames leave the latch alone; quad and protected clear it
        checkClearWel = !refuse && (locked || (malformed && isQuadCap));
        programDone = (state == CORE_TIMING) && (timer == 24'h000001);
        internalClear = ((state == CORE_CHECK) && checkClearWel) || programDone;
    end

    // ****************************************
    // Core sequencer
    // ****************************************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= CORE_IDLE;
            captured <= '0;
            copyIdx <= '0;
            timer <= '0;
        end else begin
            unique case (state)
                CORE_IDLE: begin
                    // Frames ending while busy are ignored
                    if (frameEnd && isProgram(linkFrame.opcode)) begin
                        captured <= linkFrame;
                        state <= CORE_CHECK;
                    end
                end
                CORE_CHECK: begin
                    copyIdx <= '0;
                    state <= checkOk ? CORE_COPY : CORE_IDLE;
                end
                CORE_COPY: begin
                    copyIdx <= 8'(copyIdx + 8'h01);
                    if (copyIdx == PAGE_LAST) begin
                        timer <= (captured.byteCount == 9'h001) ? BP_CYCLES : PP_CYCLES;
                        state <= CORE_TIMING;
                    end
                end
                CORE_TIMING: begin
                    timer <= 24'(timer - 24'h000001);
                    if (programDone) begin
                        state <= CORE_IDLE;
                    end
                end
                default: begin
                    state <= CORE_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Array write
    // ****************************************
    // Only locations that received a byte are written
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            arrayWrite <= '0;
        end else if ((state == CORE_COPY) && rdValid) begin
            arrayWrite.wrEn <= 1'b1;
            arrayWrite.addr <= {captured.startAddr[23:8], copyIdx};
            arrayWrite.data <= rdData;
        end else begin
            arrayWrite.wrEn <= 1'b0;
        end
    end

    // ****************************************
    // Status
    // ****************************************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            readyBusyFlag <= 1'b0;
        end else if ((state == CORE_CHECK) && checkOk) begin
            readyBusyFlag <= 1'b1;
        end else if (programDone) begin
            readyBusyFlag <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            programAborted <= 1'b0;
        end else begin
            programAborted <= (state == CORE_CHECK) && checkAbort;
        end
    end

    // A set arriving with a clear wins so the host's enable is never lost
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            writeEnableLatch <= WEL_RESET;
        end else if (writeEnableSet) begin
            writeEnableLatch <= 1'b1;
        end else if (writeEnableClear || internalClear) begin
            writeEnableLatch <= 1'b0;
        end
    end

endmodule

// ### mip_page_buf.sv
// Purpose: 256-byte page buffer with a written-location mask.
// Assumes: Written on the link clock, read only while the link is quiet.
// Notes: Read port is combinational so the core can walk it after the frame.

module mip_page_buf import mip_pkg::*; (
    // Write side, link clock
    input wire logic wrClk,
    input wire logic clearMask,
    input wire logic wrEn,
    input wire logic [7:0] wrIdx,
    input wire logic [7:0] wrData,
    // Read side, core clock
    input wire logic [7:0] rdIdx,
    output logic [7:0] rdData,
    output logic rdValid
);
    logic [7:0] mem [0:PAGE_BYTES-1];
    logic [PAGE_BYTES-1:0] mask;

    always_ff @(posedge wrClk) begin
        if (wrEn) begin
            mem[wrIdx] <= wrData;
        end
    end

    // Later bytes overwrite earlier ones, so only the last page survives
    always_ff @(posedge wrClk) begin
        if (clearMask) begin
            mask <= '0;
        end else if (wrEn) begin
            mask[wrIdx] <= 1'b1;
        end
    end

    assign rdData = mem[rdIdx];
    assign rdValid = mask[rdIdx];
endmodule

// ### mip_pkg.sv
// Purpose: Shared constants, types and helpers for the multi-lane page program path.
// Assumes: Core clock of 100 MHz; link clock driven by the host only while chip select is low.
// Notes: Opcodes, header layout, lane phases and state codes live here only.
//
// Overview of operation
// - Program only runs when the write enable latch is set beforehand.
// - Dual program: command and address on one lane, then output line becomes input.
// - Opcode takes eight link clocks on the input line, most significant bit first.
// - Then 24 address bits over 24 clocks on input line, bit 23 first.
// - Dual data: four clocks per byte, high bit on output line, low on input.
// - Received bytes are buffered and written to the array after chip select rises.
// - Ready/busy flag stays high while the self-timed programming runs.
// - Active status mode drives ready/busy onto output line, refreshed every clock.
// - Bytes past the page end wrap to the start of the same page.
// - Unsent locations keep contents; beyond 256 bytes only the last 256 remain.
// - Dual: missing address, no full byte or odd bit count aborts, nothing programmed.
// - Protected block: skip program, back to idle, clear write enable latch.
// - Quad program needs both write enable latch and quad lane enable bit.
// - Quad: after last address byte, output line turns input; four lanes carry data.
// - Quad data: two clocks per byte, high nibble first, hold line highest.
// - Quad: chip select released off a byte boundary aborts, nothing programmed, write enable latch cleared.
// - Quad: incomplete address or data byte aborts and clears write enable latch.

package mip_pkg;

    // ****************************************
    // Opcodes
    // ****************************************
    localparam logic [7:0] OPC_DUAL_PROGRAM = 8'hA2;
    localparam logic [7:0] OPC_QUAD_PROGRAM = 8'h32;
    localparam logic [7:0] OPC_ACTIVE_STATUS = 8'h25;

    // ****************************************
    // Frame layout and timing
    // ****************************************
    localparam logic [5:0] HDR_BITS = 6'h20;
    localparam logic [5:0] OPC_LAST_BIT = 6'h07;
    localparam logic [5:0] ADDR_LAST_BIT = 6'h1F;
    localparam logic [8:0] PAGE_BYTES = 9'h100;
    localparam logic [7:0] PAGE_LAST = 8'hFF;
    localparam logic [1:0] DUAL_LAST_PHASE = 2'h3;
    localparam logic [1:0] QUAD_LAST_PHASE = 2'h1;
    localparam logic WEL_RESET = 1'b0;
    localparam int CLK_PERIOD_NS = 10;

    typedef enum logic [1:0] {
        LANE_SINGLE = 2'b00,
        LANE_DUAL = 2'b01,
        LANE_QUAD = 2'b10
    } mip_lane_e;

    typedef enum logic [2:0] {
        CORE_IDLE = 3'b000,
        CORE_CHECK = 3'b001,
        CORE_COPY = 3'b010,
        CORE_TIMING = 3'b011
    } mip_core_e;

    typedef struct packed {
        logic [7:0] opcode;
        logic [23:0] startAddr;
        logic [8:0] byteCount;
        logic headerDone;
        logic partialByte;
    } mip_frame_s;

    typedef struct packed {
        logic wrEn;
        logic [23:0] addr;
        logic [7:0] data;
    } mip_array_wr_s;

    function automatic logic isProgram(input logic [7:0] op);
        return (op == OPC_DUAL_PROGRAM) || (op == OPC_QUAD_PROGRAM);
    endfunction

    // Shortest-time style: round down, never below one cycle
    function automatic logic [23:0] nsToCycles(input int ns);
        int c;
        c = ns / CLK_PERIOD_NS;
        if (c < 1) begin
            c = 1;
        end
        return c[23:0];
    endfunction

endpackage

// ### mip_pp_sva.sv
// Purpose: Port-level checks of the page program path.
// Assumes: Byte program time comes from the top's parameter.
// Notes: Bound to every instance of the top module.
module mip_pp_sva import mip_pkg::*; #(
    parameter int BYTE_PROGRAM_TIME_NS = 10000
) (
    // Core
    input wire logic clock,
    input wire logic rst_n,
    // Link
    input wire logic csN,
    input wire logic soOut,
    input wire logic soOeN,
    // Control and status
    input wire logic writeEnableSet,
    input wire logic writeEnableClear,
    input wire logic writeEnableLatch,
    input wire logic readyBusyFlag,
    input wire logic programAborted,
    input wire mip_array_wr_s arrayWrite
);
    // ****
    // Busy length counter
    // ****
    // Copy walks all 256 offsets, then the shortest timed wait
    localparam int MIN_BUSY = 255 + BYTE_PROGRAM_TIME_NS / CLK_PERIOD_NS;
    int busyCnt;
    always_ff @(posedge clock) begin
        if (!rst_n || !readyBusyFlag) begin
            busyCnt <= 0;
        end else begin
            busyCnt <= busyCnt + 1;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ****
    // Assertions
    // ****
    latch_set_a: assert property (writeEnableSet |=> writeEnableLatch)
        else $error("latch not set");
    latch_clear_a: assert property (writeEnableClear && !writeEnableSet |=> !writeEnableLatch)
        else $error("latch not cleared");
    start_latched_a: assert property ($rose(readyBusyFlag) |-> writeEnableLatch)
        else $error("program started without latch");
    write_busy_a: assert property (arrayWrite.wrEn |-> readyBusyFlag)
        else $error("array write while idle");
    page_walk_a: assert property (arrayWrite.wrEn ##1 arrayWrite.wrEn |-> arrayWrite.addr == $past(arrayWrite.addr) + 24'h000001)
        else $error("array writes left the page order");
    abort_quiet_a: assert property (programAborted |-> !readyBusyFlag ##1 (!readyBusyFlag && !arrayWrite.wrEn)[*8])
        else $error("aborted frame still programmed");
    abort_pulse_a: assert property (programAborted |=> !programAborted)
        else $error("abort pulse too long");
    busy_length_a: assert property ($fell(readyBusyFlag) |-> busyCnt >= MIN_BUSY)
        else $error("busy too short");
    done_latch_a: assert property ($fell(readyBusyFlag) |-> !writeEnableLatch)
        else $error("latch kept after program");
    link_idle_a: assert property (csN && $past(csN) |-> soOeN && !soOut)
        else $error("output line driven while deselected");
endmodule

bind mip_multi_io_page_program mip_pp_sva #(.BYTE_PROGRAM_TIME_NS(BYTE_PROGRAM_TIME_NS)) u_sva (
    .clock(clock), .rst_n(rst_n), .csN(csN), .soOut(soOut), .soOeN(soOeN),
    .writeEnableSet(writeEnableSet), .writeEnableClear(writeEnableClear),
    .writeEnableLatch(writeEnableLatch), .readyBusyFlag(readyBusyFlag),
    .programAborted(programAborted), .arrayWrite(arrayWrite));

// ### mip_sync.sv
// Purpose: Two-flop level synchroniser.
// Assumes: Input is a level that holds long enough to be seen.
// Notes: First flop feeds only the second flop.

module mip_sync #(
    parameter logic INIT = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstN,
    // Level
    input wire logic d,
    output logic q
);
    logic meta;

    always_ff @(posedge clk) begin
        if (!rstN) begin
            meta <= INIT;
            q <= INIT;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// ### tb_multi_io_page_program.sv
// Purpose: Self-checking bench for the multi-lane page program path.
// Assumes: Program times shortened by parameter.
// Notes: Array writes are collected and compared per page offset.
module tb_multi_io_page_program import mip_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic weSet = 1'b0;
    logic weClr = 1'b0;
    logic qe = 1'b0;
    logic [63:0] lockMap = 64'h0;
    logic spiClk, csN, siH, soH, wpH, holdH, soOut, soOeN, soLine, write_enable_latch, busy, aborted;
    mip_array_wr_s aw;
    int fail_count = 0;
    int checks_done = 0;
    int wrCnt = 0;
    int abortCnt = 0;
    logic [7:0] wrMem [logic [23:0]];
    always #5 clock = ~clock;
    assign soLine = soOeN ? soH : soOut;
    // Write pulse stands one cycle, so the falling edge sees it settled
    always @(negedge clock) if (aw.wrEn === 1'b1) begin
        wrMem[aw.addr] = aw.data;
        wrCnt++;
    end
    // Abort pulse rises inside the host's gap after chip select rises and falls after that gap ends
    always @(negedge clock) if (aborted === 1'b1) abortCnt++;
    mip_multi_io_page_program #(.PAGE_PROGRAM_TIME_NS(500), .BYTE_PROGRAM_TIME_NS(200)) u_dut (
        .clock(clock), .rst_n(rst_n), .spiClk(spiClk), .csN(csN), .siIn(siH), .soIn(soLine),
        .soOut(soOut), .soOeN(soOeN), .wpIn(wpH), .holdIn(holdH), .writeEnableSet(weSet),
        .writeEnableClear(weClr), .quadLaneEnableBit(qe), .blockLockMap(lockMap),
        .writeEnableLatch(write_enable_latch), .readyBusyFlag(busy), .programAborted(aborted), .arrayWrite(aw));
    mip_host_model u_host (.spiClk(spiClk), .csN(csN), .siH(siH), .soH(soH), .wpH(wpH),
        .holdH(holdH), .soLine(soLine));
    // ****
    // Tasks
    // ****
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic pulse_latch(input logic on);
        @(negedge clock);
        weSet = on;
        weClr = !on;
        @(negedge clock);
        weSet = 1'b0;
        weClr = 1'b0;
    endtask
    task automatic expect_page(input logic [23:0] addr, input int n, input logic [7:0] seed, input logic ok);
        logic [7:0] e [0:255];
        logic hit [0:255];
        int cnt;
        cnt = 0;
        foreach (hit[o]) hit[o] = 1'b0;
        for (int k = 0; k < n; k++) begin
            e[8'(addr[7:0] + k)] = u_host.dat(seed, k);
            hit[8'(addr[7:0] + k)] = ok;
        end
        foreach (hit[o]) if (hit[o]) begin
            cnt++;
            check("array byte", wrMem[{addr[23:8], 8'(o)}], e[o]);
        end
        check("array writes", wrCnt, cnt);
    endtask
    task automatic prog(input string name, input logic [7:0] op, input logic [23:0] addr, input int hdr,
        input int n, input int extra, input logic weOn, input logic quad, input logic [2:0] exp);
        logic sawBusy;
        sawBusy = 1'b0;
        wrMem.delete();
        wrCnt = 0;
        abortCnt = 0;
        qe = quad;
        pulse_latch(weOn);
        u_host.send(op, addr, hdr, n, extra);
        for (int i = 0; i < 1000 && (i < 20 || busy); i++) begin
            @(negedge clock);
            sawBusy |= busy;
        end
        check("busy seen", sawBusy, exp[2]);
        check("abort seen", abortCnt, exp[1]);
        check("latch", write_enable_latch, exp[0]);
        expect_page(addr, n, op ^ addr[15:8], exp[2]);
        $display("test %s done", name);
    endtask
    // ****
    // Tests
    // ****
    // About 25 us of tests; the limit allows sixteen times that
    initial begin
        #400000;
        fail_count++;
        give_verdict();
    end
    initial begin
        logic hi, fall;
        repeat (10) @(negedge clock);
        rst_n = 1'b1;
        repeat (3) @(negedge clock);
        check("reset latch", write_enable_latch, 1'b0);
        check("reset oe", soOeN, 1'b1);
        $display("test reset done");
        prog("no latch", OPC_DUAL_PROGRAM, 24'h000010, 32, 2, 0, 0, 0, 3'b000);
        prog("dual wrap", OPC_DUAL_PROGRAM, 24'h0000FE, 32, 3, 0, 1, 0, 3'b100);
        prog("quad no qe", OPC_QUAD_PROGRAM, 24'h000020, 32, 1, 0, 1, 0, 3'b001);
        prog("quad over", OPC_QUAD_PROGRAM, 24'h001234, 32, 258, 0, 1, 1, 3'b100);
        prog("dual odd", OPC_DUAL_PROGRAM, 24'h000300, 32, 1, 3, 1, 0, 3'b011);
        prog("dual short", OPC_DUAL_PROGRAM, 24'h000300, 20, 0, 0, 1, 0, 3'b011);
        prog("dual empty", OPC_DUAL_PROGRAM, 24'h000300, 32, 0, 0, 1, 0, 3'b011);
        prog("quad odd", OPC_QUAD_PROGRAM, 24'h000400, 32, 2, 1, 1, 1, 3'b010);
        prog("quad short", OPC_QUAD_PROGRAM, 24'h000400, 28, 0, 0, 1, 1, 3'b010);
        lockMap[2] = 1'b1;
        prog("locked", OPC_DUAL_PROGRAM, 24'h020010, 32, 1, 0, 1, 0, 3'b010);
        lockMap = 64'h0;
        pulse_latch(1'b1);
        wrMem.delete();
        wrCnt = 0;
        u_host.send(OPC_DUAL_PROGRAM, 24'h000040, 32, 1, 0);
        for (int i = 0; i < 20 && busy !== 1'b1; i++) @(negedge clock);
        u_host.status(400, hi, fall);
        check("status high", hi, 1'b1);
        check("status fall", fall, 1'b1);
        check("busy after", busy, 1'b0);
        expect_page(24'h000040, 1, OPC_DUAL_PROGRAM, 1'b1);
        $display("test status done");
        give_verdict();
    end
endmodule
